// *** pkg/pcs_pkg.sv ***
// Shared constants for the program counter, return stack and indirect path.
`default_nettype none
package pcs_pkg;
	// Widths of the address and data paths.
	localparam int PC_W     = 13;
	localparam int PAGE_W   = 11;
	localparam int DATA_W   = 8;
	localparam int LATCH_W  = 5;
	localparam int DADDR_W  = 9;
	localparam int APB_AW   = 8;
	localparam int APB_DW   = 32;
	localparam int STK_DEPTH = 8;
	localparam int STK_PTR_W = 3;
	// Register byte offsets on the APB port.
	localparam logic [APB_AW-1:0] ADDR_PC_LOW   = 8'h00;
	localparam logic [APB_AW-1:0] ADDR_LATCH    = 8'h04;
	localparam logic [APB_AW-1:0] ADDR_FPTR     = 8'h08;
	localparam logic [APB_AW-1:0] ADDR_BANK     = 8'h0C;
	localparam logic [APB_AW-1:0] ADDR_INDIRECT = 8'h10;
	// Field positions inside the latch and bank registers.
	localparam int LATCH_PAGE_HI = 4;
	localparam int LATCH_PAGE_LO = 3;
	localparam int BANK_IND_BIT   = 7;
	localparam int BANK_UPPER_BIT = 6;
	// Reset values and fixed answers.
	localparam logic [PC_W-1:0]    PC_RST    = 13'h0000;
	localparam logic [LATCH_W-1:0] LATCH_RST = 5'h00;
	localparam logic [DATA_W-1:0]  FPTR_RST  = 8'h00;
	localparam logic [DATA_W-1:0]  SELF_PTR  = 8'h00;
	localparam logic [DATA_W-1:0]  SELF_READ = 8'h00;
	localparam logic [PC_W-1:0]    PC_ONE    = 13'h0001;
	// Interrupt vector; the value is an arbitrary plain default.
	localparam logic [PC_W-1:0]    IRQ_VECTOR = 13'h0004;
	// Operation chosen for the program counter in one cycle.
	typedef enum logic [2:0] {
		OP_HOLD, OP_STEP, OP_JUMP, OP_CALL, OP_RETURN, OP_VECTOR, OP_LOAD_LOW
	} pc_op_t;
endpackage
`default_nettype wire

// *** verilog/return_stack.sv ***
// Circular return-address stack with no overflow or underflow status.
`default_nettype none
module return_stack #(
	parameter int DEPTH = pcs_pkg::STK_DEPTH,
	parameter int WIDTH = pcs_pkg::PC_W
) (
	input  wire logic                      clk_sys,
	input  wire logic                      arst_n,
	input  wire logic                      push,
	input  wire logic                      pop,
	input  wire logic [WIDTH-1:0]          push_data,
	output logic      [WIDTH-1:0]          top_data
);
	import pcs_pkg::*;
	localparam int PW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [WIDTH-1:0] mem_d [DEPTH];
	logic [PW-1:0]    ptr_q;
	logic [PW-1:0]    ptr_d;

	// The entry below the pointer is the top; an empty stack still yields
	// whatever slot that is, which is why no status flag exists.
	assign top_data = mem_q[PW'(ptr_q - PW'(1))]; // see R19

	// Push writes the free slot and advances; pop steps back. The pointer
	// wraps so a ninth push overwrites the oldest entry.
	always_comb begin
		mem_d = mem_q;
		ptr_d = ptr_q;
		if (push) begin
			mem_d[ptr_q] = push_data; // see R10
			ptr_d = PW'(ptr_q + PW'(1)); // see R10
		end else if (pop) begin
			ptr_d = PW'(ptr_q - PW'(1)); // see R19
		end
	end

	// Registers only; the pointer is not visible to software.
	always_ff @(posedge clk_sys or negedge arst_n) begin // see R06
		if (!arst_n) begin
			ptr_q <= '0;
			for (int i = 0; i < DEPTH; i++) begin
				mem_q[i] <= '0;
			end
		end else begin
			ptr_q <= ptr_d;
			mem_q <= mem_d;
		end
	end

	// A push followed by a pop hands back the pushed value.
	property p_push_pop;
		@(posedge clk_sys) disable iff (!arst_n)
		push ##1 (pop && !push) |-> top_data == $past(push_data);
	endproperty
	a_push_pop: assert property (p_push_pop) // see R08
		else $error("pop did not return the last pushed value");

	// Eight pushes in a row bring the pointer back where it started.
	property p_wrap;
		@(posedge clk_sys) disable iff (!arst_n)
		push [*8] |=> ptr_q == $past(ptr_q, 8);
	endproperty
	a_wrap: assert property (p_wrap) // see R10
		else $error("stack pointer did not wrap after eight pushes");
endmodule // return_stack
`default_nettype wire

// *** verilog/program_counter_stack_indirect.sv ***
// Program counter, page latch, return stack and indirect addressing.
//
// Notes on behaviour
// R01 - Thirteen-bit counter; low byte readable and writable.
// R02 - Counter bits 12..8 never readable by software.
// R03 - Every reset clears the counter.
// R04 - Low write loads byte, latch 4..0 high.
// R05 - Jump/call: 11 target bits, latch 4..3 top.
// R06 - Eight by thirteen stack, pointer hidden.
// R07 - Call and interrupt vectoring push the counter.
// R08 - All three returns pop full counter; the code has a single return, op_return.
// R09 - Pushes and pops leave latch untouched.
// R10 - Circular stack; ninth push overwrites first.
// R11 - No overflow or underflow indication.
// R12 - Eight K words in two K pages.
// R13 - Software avoids latch bit 4 as storage.
// R14 - Indirect register reaches the pointed register.
// R15 - Indirect read with zero pointer gives 00h.
// R16 - Indirect self write changes no register.
// R17 - Data address is bank bit plus pointer.
// R18 - Software keeps both high bank bits clear.
// R19 - Empty pop returns selected slot; pointer wraps.
`default_nettype none
module program_counter_stack_indirect #(
	parameter logic [pcs_pkg::PC_W-1:0] VECTOR = pcs_pkg::IRQ_VECTOR
) (
	input  wire logic                           clk_sys,
	input  wire logic                           arst_n,
	input  wire logic                           psel,
	input  wire logic                           penable,
	input  wire logic                           pwrite,
	input  wire logic [pcs_pkg::APB_AW-1:0]     paddr,
	input  wire logic [pcs_pkg::APB_DW-1:0]     pwdata,
	output logic      [pcs_pkg::APB_DW-1:0]     prdata,
	output logic                                pready,
	output logic                                pslverr,
	input  wire logic                           op_step,
	input  wire logic                           op_jump,
	input  wire logic                           op_call,
	input  wire logic                           op_return,
	input  wire logic                           op_interrupt,
	input  wire logic [pcs_pkg::PAGE_W-1:0]     branch_target,
	output logic      [pcs_pkg::PC_W-1:0]       pc,
	output logic                                upper_bank_select_bit,
	output logic      [pcs_pkg::DADDR_W-1:0]    mem_addr,
	output logic                                mem_rd,
	output logic                                mem_wr,
	output logic      [pcs_pkg::DATA_W-1:0]     mem_wdata,
	input  wire logic [pcs_pkg::DATA_W-1:0]     mem_rdata
);
	import pcs_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Bus decode.

	// True when the bus address selects the register at the given offset.
	function automatic logic hit(input logic [APB_AW-1:0] a,
		input logic [APB_AW-1:0] off);
		return a == off;
	endfunction

	logic mapped;
	logic setup_ph;
	logic write_go;
	logic pcl_wr;
	logic latch_wr;
	logic fptr_wr;
	logic bank_wr;
	logic ind_wr;
	logic ind_rd;
	logic ind_self;

	// Every transfer completes in its first access cycle, so pready only
	// follows the access phase; unmapped offsets answer with pslverr.
	assign mapped = hit(paddr, ADDR_PC_LOW) | hit(paddr, ADDR_LATCH)
		| hit(paddr, ADDR_FPTR) | hit(paddr, ADDR_BANK)
		| hit(paddr, ADDR_INDIRECT);
	assign setup_ph = psel & ~penable;
	assign pready   = psel & penable;
	assign pslverr  = psel & penable & ~mapped;
	assign write_go = psel & penable & pwrite;

	// Write strobes last exactly the completing access cycle.
	assign pcl_wr   = write_go & hit(paddr, ADDR_PC_LOW);
	assign latch_wr = write_go & hit(paddr, ADDR_LATCH);
	assign fptr_wr  = write_go & hit(paddr, ADDR_FPTR);
	assign bank_wr  = write_go & hit(paddr, ADDR_BANK);
	assign ind_wr   = write_go & hit(paddr, ADDR_INDIRECT);
	assign ind_rd   = setup_ph & ~pwrite & hit(paddr, ADDR_INDIRECT);

	////////////////////////////////////////////////////////////////////////
	// Program counter and page latch.

	logic [PC_W-1:0]    pc_q;
	logic [PC_W-1:0]    pc_d;
	logic [LATCH_W-1:0] latch_q;
	logic [LATCH_W-1:0] latch_d;
	logic               push;
	logic               pop;
	logic [PC_W-1:0]    push_data;
	logic [PC_W-1:0]    stack_top;
	pc_op_t             op;

	assign pc = pc_q;

	// One operation per cycle. A software load of the low byte wins over
	// the decoder, then vectoring, call, jump, return and plain stepping.
	always_comb begin
		op = OP_HOLD;
		if (pcl_wr) begin
			op = OP_LOAD_LOW;
		end else if (op_interrupt) begin
			op = OP_VECTOR;
		end else if (op_call) begin
			op = OP_CALL;
		end else if (op_jump) begin
			op = OP_JUMP;
		end else if (op_return) begin
			op = OP_RETURN;
		end else if (op_step) begin
			op = OP_STEP;
		end
	end

	// Next counter value and stack request. The latch is written only by
	// software, so branches and returns never disturb it.
	always_comb begin
		pc_d      = pc_q;
		push      = 1'b0;
		pop       = 1'b0;
		push_data = pc_q;
		latch_d   = latch_wr ? pwdata[LATCH_W-1:0] : latch_q; // see R09
		case (op)
			OP_LOAD_LOW: begin
				pc_d = {latch_q, pwdata[DATA_W-1:0]}; // see R04
			end
			OP_VECTOR: begin
				push = 1'b1; // see R07
				pc_d = VECTOR;
			end
			OP_CALL: begin
				push      = 1'b1; // see R07
				push_data = pc_q + PC_ONE;
				pc_d = {latch_q[LATCH_PAGE_HI:LATCH_PAGE_LO],
					branch_target}; // see R05
			end
			OP_JUMP: begin
				pc_d = {latch_q[LATCH_PAGE_HI:LATCH_PAGE_LO],
					branch_target}; // see R12
			end
			OP_RETURN: begin
				pop  = 1'b1;
				pc_d = stack_top; // see R08
			end
			OP_STEP: begin
				pc_d = pc_q + PC_ONE; // see R12
			end
			default: begin
				pc_d = pc_q;
			end
		endcase
	end

	// Any reset that reaches this block clears the whole counter.
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			pc_q    <= PC_RST; // see R03
			latch_q <= LATCH_RST;
		end else begin
			pc_q    <= pc_d; // see R01
			latch_q <= latch_d;
		end
	end

	// The stack reports nothing beyond its top entry.
	return_stack #(
		.DEPTH (STK_DEPTH),
		.WIDTH (PC_W)
	) u_stack (
		.clk_sys   (clk_sys),
		.arst_n    (arst_n),
		.push      (push),
		.pop       (pop),
		.push_data (push_data),
		.top_data  (stack_top)
	); // see R11

	////////////////////////////////////////////////////////////////////////
	// File pointer, bank bits and the indirect path.

	logic [DATA_W-1:0] fptr_q;
	logic [DATA_W-1:0] fptr_d;
	logic              ibank_q;
	logic              ibank_d;
	logic              ubank_q;
	logic              ubank_d;

	assign upper_bank_select_bit = ubank_q;

	// Pointer and bank bits are plain software storage.
	always_comb begin
		fptr_d  = fptr_wr ? pwdata[DATA_W-1:0] : fptr_q;
		ibank_d = bank_wr ? pwdata[BANK_IND_BIT] : ibank_q;
		ubank_d = bank_wr ? pwdata[BANK_UPPER_BIT] : ubank_q;
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			fptr_q  <= FPTR_RST;
			ibank_q <= 1'b0;
			ubank_q <= 1'b0;
		end else begin
			fptr_q  <= fptr_d;
			ibank_q <= ibank_d;
			ubank_q <= ubank_d;
		end
	end

	// The indirect register holds nothing; accesses go to memory at the
	// address made of the bank bit above the pointer.
	assign ind_self  = fptr_q == SELF_PTR;
	assign mem_addr  = {ibank_q, fptr_q}; // see R17
	assign mem_wdata = pwdata[DATA_W-1:0];
	assign mem_rd    = ind_rd & ~ind_self; // see R14
	assign mem_wr    = ind_wr & ~ind_self; // see R16

	////////////////////////////////////////////////////////////////////////
	// Read data.

	logic [APB_DW-1:0] prdata_q;
	logic [APB_DW-1:0] prdata_d;

	assign prdata = prdata_q;

	// Read data is captured in the setup cycle, so memory must answer in
	// the same cycle that mem_rd is high. The high counter bits never
	// appear here; only the latch is visible.
	always_comb begin
		prdata_d = prdata_q;
		if (setup_ph & ~pwrite) begin
			prdata_d = '0;
			if (hit(paddr, ADDR_PC_LOW)) begin
				prdata_d[DATA_W-1:0] = pc_q[DATA_W-1:0]; // see R02
			end else if (hit(paddr, ADDR_LATCH)) begin
				prdata_d[LATCH_W-1:0] = latch_q;
			end else if (hit(paddr, ADDR_FPTR)) begin
				prdata_d[DATA_W-1:0] = fptr_q;
			end else if (hit(paddr, ADDR_BANK)) begin
				prdata_d[BANK_IND_BIT]   = ibank_q;
				prdata_d[BANK_UPPER_BIT] = ubank_q;
			end else if (hit(paddr, ADDR_INDIRECT)) begin
				prdata_d[DATA_W-1:0] = ind_self ? SELF_READ
					: mem_rdata; // see R15
			end
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			prdata_q <= '0;
		end else begin
			prdata_q <= prdata_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks.

	property p_low_load;
		@(posedge clk_sys) disable iff (!arst_n)
		pcl_wr |=> pc_q == {$past(latch_q), $past(pwdata[DATA_W-1:0])};
	endproperty
	a_low_load: assert property (p_low_load) // see R04
		else $error("low byte write loaded the counter wrongly");

	property p_jump_page;
		@(posedge clk_sys) disable iff (!arst_n)
		(op_jump && !op_call && !op_interrupt && !pcl_wr)
		|=> pc_q[PC_W-1:PAGE_W] == $past(latch_q[LATCH_PAGE_HI:LATCH_PAGE_LO])
		&& pc_q[PAGE_W-1:0] == $past(branch_target);
	endproperty
	a_jump_page: assert property (p_jump_page) // see R05
		else $error("jump target not paged from the latch");

	property p_call_push;
		@(posedge clk_sys) disable iff (!arst_n)
		(op_call && !op_interrupt && !pcl_wr)
		|=> stack_top == $past(pc_q) + PC_ONE;
	endproperty
	a_call_push: assert property (p_call_push) // see R07
		else $error("call did not push the return address");

	property p_vector;
		@(posedge clk_sys) disable iff (!arst_n)
		(op_interrupt && !pcl_wr)
		|=> pc_q == VECTOR && stack_top == $past(pc_q);
	endproperty
	a_vector: assert property (p_vector) // see R07
		else $error("interrupt did not push and vector");

	property p_return;
		@(posedge clk_sys) disable iff (!arst_n)
		(op == OP_RETURN) |=> pc_q == $past(stack_top);
	endproperty
	a_return: assert property (p_return) // see R08
		else $error("return did not restore the full counter");

	property p_latch_kept;
		@(posedge clk_sys) disable iff (!arst_n)
		(push || pop) && !latch_wr |=> $stable(latch_q);
	endproperty
	a_latch_kept: assert property (p_latch_kept) // see R09
		else $error("latch changed on a push or pop");

	property p_self_read;
		@(posedge clk_sys) disable iff (!arst_n)
		(ind_rd && ind_self) |=> prdata_q == '0 ##1 !mem_wr;
	endproperty
	a_self_read: assert property (p_self_read) // see R15
		else $error("indirect self read did not return zero");

	property p_self_write;
		@(posedge clk_sys) disable iff (!arst_n)
		(ind_wr && ind_self) |-> !mem_wr ##1 $stable(fptr_q);
	endproperty
	a_self_write: assert property (p_self_write) // see R16
		else $error("indirect self write reached a register");

	property p_eff_addr;
		@(posedge clk_sys) disable iff (!arst_n)
		bank_wr |=> mem_addr[DADDR_W-1] == $past(pwdata[BANK_IND_BIT]);
	endproperty
	a_eff_addr: assert property (p_eff_addr) // see R17
		else $error("indirect bank bit not on the address");

	property p_high_hidden;
		@(posedge clk_sys) disable iff (!arst_n)
		(setup_ph && !pwrite && hit(paddr, ADDR_PC_LOW))
		|=> prdata_q[APB_DW-1:DATA_W] == '0;
	endproperty
	a_high_hidden: assert property (p_high_hidden) // see R02
		else $error("counter high bits leaked onto the bus");
endmodule // program_counter_stack_indirect
`default_nettype wire

// *** test/core_partner.sv ***
// Far-side model: instruction decoder op drive and the data register file.
`default_nettype none
module core_partner (
	input  wire logic        clk_sys,
	input  wire logic [8:0]  mem_addr,
	input  wire logic        mem_rd,
	input  wire logic        mem_wr,
	input  wire logic [7:0]  mem_wdata,
	output logic      [7:0]  mem_rdata,
	output logic      [4:0]  ops,
	output logic      [10:0] target
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] ram [512];
	logic [7:0] last_q;
	int         wr_count;

	////////////////////////////////////////////////////////////////////////
	// Start idle with a patterned file so stale reads cannot pass as zero.
	initial begin
		ops = 5'h00;
		target = 11'h000;
		last_q = 8'h00;
		wr_count = 0;
		foreach (ram[i]) ram[i] = 8'(i) ^ 8'h3C;
	end

	// Read data is valid while read is strobed; otherwise it shows the
	// inverse of the last value so a late sample is caught.
	assign mem_rdata = mem_rd ? ram[mem_addr] : ~last_q;

	// The pointed register takes the byte on a write strobe.
	always @(posedge clk_sys) begin
		if (mem_rd) last_q <= ram[mem_addr];
		if (mem_wr) begin
			ram[mem_addr] <= mem_wdata;
			wr_count <= wr_count + 1;
		end
	end

	// One decoded operation for one cycle, then idle for one cycle.
	task automatic run_op(input logic [4:0] v, input logic [10:0] t);
		ops <= v;
		target <= t;
		@(posedge clk_sys);
		ops <= 5'h00;
		@(posedge clk_sys);
	endtask

	// The same code on n edges in a row, then idle for one cycle; this is
	// how the test reaches back-to-back pushes.
	task automatic run_burst(input logic [4:0] v, input logic [10:0] t,
		input int n);
		ops <= v;
		target <= t;
		repeat (n) @(posedge clk_sys);
		ops <= 5'h00;
		@(posedge clk_sys);
	endtask

	// Two codes on consecutive edges, then idle for one cycle.
	task automatic run_pair(input logic [4:0] v1, input logic [4:0] v2,
		input logic [10:0] t);
		ops <= v1;
		target <= t;
		@(posedge clk_sys);
		ops <= v2;
		@(posedge clk_sys);
		ops <= 5'h00;
		@(posedge clk_sys);
	endtask
endmodule // core_partner
`default_nettype wire

// *** test/test_program_counter_stack_indirect.sv ***
// Testbench for the program counter, return stack and indirect path.
`default_nettype none
module test_program_counter_stack_indirect;
	timeunit 1ns;
	timeprecision 1ns;
	import pcs_pkg::*;
	logic              clk_sys = 1'b0;
	logic              arst_n = 1'b0;
	logic              psel = 1'b0;
	logic              penable = 1'b0;
	logic              pwrite = 1'b0;
	logic [APB_AW-1:0] paddr = 8'h00;
	logic [APB_DW-1:0] pwdata = 32'h0;
	logic [APB_DW-1:0] prdata;
	logic              pready, pslverr, ubank, mem_rd, mem_wr;
	logic [PC_W-1:0]   pc;
	logic [8:0]        mem_addr;
	logic [7:0]        mem_wdata, mem_rdata;
	logic [4:0]        ops;
	logic [10:0]       target;
	int                failures = 0;
	int                tests_run = 0;
	int                cycles = 0;

	////////////////////////////////////////////////////////////////////////
	program_counter_stack_indirect u_program_counter_stack_indirect (
		.clk_sys(clk_sys), .arst_n(arst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .op_step(ops[0]), .op_jump(ops[1]),
		.op_call(ops[2]), .op_return(ops[3]), .op_interrupt(ops[4]),
		.branch_target(target), .pc(pc), .upper_bank_select_bit(ubank),
		.mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
		.mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
	core_partner u_core_partner (
		.clk_sys(clk_sys), .mem_addr(mem_addr), .mem_rd(mem_rd),
		.mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
		.ops(ops), .target(target));

	// Free-running clock and a hang guard well above the run length.
	always #20 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 5000) begin
			failures++;
			stop_test();
		end
	end

	////////////////////////////////////////////////////////////////////////
	task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// One APB transfer; the request holds until pready is seen high.
	task automatic apb(input logic [7:0] a, input logic w,
		input logic [31:0] d, output logic [31:0] r, output logic e);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		// No wait-state count is assumed; the cycle guard ends a hang.
		do begin
			@(posedge clk_sys);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(a, 1'b1, d, r, e);
		check("wr_err", {31'h0, e}, 32'h0);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] r;
		logic        e;
		apb(a, 1'b0, 32'h0, r, e);
		check("rd_data", r, exp);
	endtask

	task automatic stop_test();
		$display("checks %0d failures %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	// Main sequence of register, flow and indirect scenarios.
	initial begin
		logic [12:0] stk [10];
		logic [12:0] prev;
		logic [31:0] r;
		logic        e;
		repeat (20) @(posedge clk_sys);
		arst_n <= 1'b1;
		@(posedge clk_sys);
		check("pc_rst", 32'(pc), 32'h0);
		rd(ADDR_LATCH, 32'h0);
		// Latch bit 4 feeds counter bit 12, and the latch also keeps it as readable storage.
		wr(ADDR_LATCH, 32'h0000_0015);
		wr(ADDR_PC_LOW, 32'h0000_00A5);
		check("pc_low_wr", 32'(pc), 32'h0000_15A5);
		rd(ADDR_PC_LOW, 32'h0000_00A5);
		u_core_partner.run_op(5'h01, 11'h000);
		check("pc_step", 32'(pc), 32'h0000_15A6);
		wr(ADDR_LATCH, 32'h0000_0018);
		u_core_partner.run_op(5'h02, 11'h123);
		check("pc_jump", 32'(pc), 32'h0000_1923);
		// Nine calls into eight slots: the ninth pop sees the ninth push.
		wr(ADDR_LATCH, 32'h0000_0000);
		u_core_partner.run_op(5'h02, 11'h010);
		prev = 13'h0010;
		for (int k = 1; k <= 9; k++) begin
			stk[k] = prev + 13'h0001;
			u_core_partner.run_op(5'h04, 11'h100 + 11'(k * 8));
			prev = {2'b00, 11'h100 + 11'(k * 8)};
			check("pc_call", 32'(pc), 32'(prev));
		end
		for (int j = 1; j <= 9; j++) begin
			u_core_partner.run_op(5'h08, 11'h000);
			check("pc_ret", 32'(pc), 32'(stk[j == 9 ? 9 : 10 - j]));
		end
		prev = pc;
		wr(ADDR_LATCH, 32'h0000_0018);
		u_core_partner.run_op(5'h10, 11'h000);
		check("pc_vec", 32'(pc), 32'(IRQ_VECTOR));
		u_core_partner.run_op(5'h08, 11'h000);
		check("pc_reti", 32'(pc), 32'(prev));
		rd(ADDR_LATCH, 32'h0000_0018);
		// Eight calls on eight edges in a row, with every lower-priority
		// code raised too, so the call must win and the pointer wraps.
		u_core_partner.run_burst(5'h0F, 11'h200, 8);
		check("pc_burst", 32'(pc), 32'h0000_1A00);
		// A call directly followed by a return hands back the push.
		u_core_partner.run_pair(5'h04, 5'h08, 11'h300);
		check("pc_pair", 32'(pc), 32'h0000_1A01);
		// Indirect access through the pointer, both banks.
		wr(ADDR_FPTR, 32'h0000_0020);
		wr(ADDR_INDIRECT, 32'h0000_005A);
		check("ram_020", 32'(u_core_partner.ram[9'h020]), 32'h5A);
		rd(ADDR_INDIRECT, 32'h0000_005A);
		wr(ADDR_BANK, 32'h0000_00C0);
		check("mem_addr", 32'(mem_addr), 32'h0000_0120);
		check("ubank", 32'(ubank), 32'h1);
		wr(ADDR_INDIRECT, 32'h0000_00C3);
		check("ram_120", 32'(u_core_partner.ram[9'h120]), 32'hC3);
		wr(ADDR_BANK, 32'h0000_0000);
		wr(ADDR_FPTR, 32'h0000_0000);
		prev = 13'(u_core_partner.wr_count);
		rd(ADDR_INDIRECT, 32'h0);
		wr(ADDR_INDIRECT, 32'h0000_0077);
		check("self_wr", 32'(u_core_partner.wr_count), 32'(prev));
		apb(8'h14, 1'b0, 32'h0, r, e);
		check("unmapped", {r[30:0], e}, 32'h1);
		// A second reset in mid-run clears the counter again.
		arst_n <= 1'b0;
		@(posedge clk_sys);
		arst_n <= 1'b1;
		@(posedge clk_sys);
		check("pc_rst2", 32'(pc), 32'h0);
		stop_test();
	end
endmodule // test_program_counter_stack_indirect
`default_nettype wire
